// file: design/pst_selftest.sv
`timescale 1ns/1ns
`default_nettype none
module pst_selftest (
    input wire logic clk, // Byte clock, 50 MHz
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic run_selftest_bit, // Run bit of control_register_a
    input wire pst_pkg::pst_obs_s obs, // Receive path end and filter signals
    input wire logic [pst_pkg::SCAN_W-1:0] fsm_scan_load, // Parallel fsm/control bits
    input wire logic seg_test_mode, // Counter segmentation test select
    input wire logic bscan_shift, // Boundary scan serial mode
    input wire logic bscan_capture, // Boundary scan parallel capture
    input wire logic test_pin0, // Boundary scan serial in
    input wire logic [pst_pkg::BSC_W-1:0] bscan_pins, // Latch values in chain order
    output logic [pst_pkg::PATH_W-1:0] test_word, // LFSR word to test data mux
    output pst_pkg::pst_mux_s mux_ctl, // Loopback and test overrides
    output logic [pst_pkg::LFSR_W-1:0] signature, // Frozen signature to host port
    output logic selftest_irq, // Completion interrupt level
    output logic selftest_busy, // Test active
    output logic [pst_pkg::SEG_W-1:0] seg_carry_cut, // Segment carry break mask
    output logic scan_out_pin // Boundary chain serial out
);
    pst_pkg::pst_state_s cur_ff, nxt_ff;
    logic active;

    //------------------------------------------------------------------
    // Next state
    //------------------------------------------------------------------
    // One process so all state moves together
    always_comb begin
        logic fb;
        logic [pst_pkg::LFSR_W-1:0] din;
        fb = 1'b0;
        din = '0;
        nxt_ff = cur_ff;
        // Two flops before the chain sees the pin
        nxt_ff.tin_sync = {cur_ff.tin_sync[0], test_pin0};
        case (cur_ff.state)
            pst_pkg::PST_IDLE: begin
                nxt_ff.irq = 1'b0;
                if (run_selftest_bit && !cur_ff.run_seen) begin // see R07
                    nxt_ff.state = pst_pkg::PST_INIT;
                    nxt_ff.init_cnt = '0;
                    nxt_ff.run_seen = 1'b1;
                end
                if (!run_selftest_bit) begin
                    nxt_ff.run_seen = 1'b0;
                end
            end
            pst_pkg::PST_INIT: begin
                nxt_ff.lfsr = pst_pkg::LFSR_SEED; // see R07
                nxt_ff.sig = pst_pkg::SIG_SEED;
                nxt_ff.scan = fsm_scan_load; // see R05
                nxt_ff.init_cnt = cur_ff.init_cnt + 3'h1;
                if (!run_selftest_bit) begin
                    nxt_ff.state = pst_pkg::PST_IDLE; // see R13
                    nxt_ff.run_seen = 1'b0;
                end else if (cur_ff.init_cnt == pst_pkg::INIT_CYCLES) begin
                    nxt_ff.state = pst_pkg::PST_RUN; // see R08
                end
            end
            pst_pkg::PST_RUN: begin
                // Galois LFSR; the step that would wrap to the seed lands on zero,
                // so exactly one full period of nonzero words goes out
                fb = cur_ff.lfsr[0];
                nxt_ff.lfsr = (cur_ff.lfsr >> 1) ^ (fb ? pst_pkg::LFSR_TAPS : '0); // see R09
                if (nxt_ff.lfsr == pst_pkg::LFSR_SEED) begin
                    nxt_ff.lfsr = '0; // see R09
                end
                // Signature compacts receive word, filter signals and scan bit
                din = {2'h0, cur_ff.scan[pst_pkg::SCAN_W-1], obs.enc_sig, // see R06
                       obs.dsg_sig, obs.rf_sig, obs.rx_word}; // see R03 see R04
                nxt_ff.sig = ({cur_ff.sig[pst_pkg::LFSR_W-2:0], 1'b0}
                             ^ (cur_ff.sig[pst_pkg::LFSR_W-1] ? pst_pkg::SIG_TAPS : '0))
                             ^ din; // see R08
                nxt_ff.scan = {cur_ff.scan[pst_pkg::SCAN_W-2:0],
                               cur_ff.scan[pst_pkg::SCAN_W-1]}; // see R05
                if (!run_selftest_bit) begin
                    nxt_ff.state = pst_pkg::PST_IDLE; // see R13
                    nxt_ff.run_seen = 1'b0;
                end else if (cur_ff.lfsr == '0) begin
                    nxt_ff.state = pst_pkg::PST_DONE; // see R09
                    nxt_ff.sig_frozen = cur_ff.sig; // see R10
                    nxt_ff.irq = 1'b1; // see R11
                end
            end
            pst_pkg::PST_DONE: begin
                // Run bit low is the only way back; reads have no effect
                if (!run_selftest_bit) begin
                    nxt_ff.irq = 1'b0; // see R12
                    nxt_ff.run_seen = 1'b0;
                    nxt_ff.state = pst_pkg::PST_IDLE; // see R22
                end
            end
            default: begin
                nxt_ff.state = pst_pkg::PST_IDLE;
            end
        endcase
        // Boundary chain: pin enters at the receive-symbol end, data bit 0 leaves first
        if (bscan_capture) begin
            nxt_ff.bsc = bscan_pins; // see R16 see R18 see R19 see R20
        end else if (bscan_shift) begin
            nxt_ff.bsc = {cur_ff.tin_sync[1], cur_ff.bsc[pst_pkg::BSC_W-1:1]}; // see R17
        end
    end

    //------------------------------------------------------------------
    // Registers
    //------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    //------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------
    // Overrides only while running, otherwise data path is untouched
    assign active = (cur_ff.state == pst_pkg::PST_INIT) || (cur_ff.state == pst_pkg::PST_RUN);
    assign mux_ctl.force_eb_loop = active; // see R01 see R21
    assign mux_ctl.force_lm_loop = active; // see R21
    assign mux_ctl.force_rem_loop = active; // see R21 see R03
    assign mux_ctl.test_sel = active; // see R02
    assign mux_ctl.scan_mode = active; // see R05
    assign mux_ctl.path_init = (cur_ff.state == pst_pkg::PST_INIT); // see R07
    assign test_word = cur_ff.lfsr[pst_pkg::PATH_W-1:0]; // see R02
    assign signature = cur_ff.sig_frozen; // see R10 see R22
    assign selftest_irq = cur_ff.irq; // see R11
    assign selftest_busy = active;
    // Every segment boundary cut while segmentation mode selected
    assign seg_carry_cut = {pst_pkg::SEG_W{seg_test_mode}}; // see R14
    assign scan_out_pin = cur_ff.bsc[0]; // see R17 see R20
endmodule // pst_selftest
`default_nettype wire

// file: design/pst_pkg.sv
//----------------------------------------------------------------------
// Overview of operation
// R01 - Test logic is passive in normal operation; acts only while test runs.
// R02 - Self test injects LFSR words at transmit output, loops to framer input.
// R03 - Words leaving receive path feed signature and loop into transmit path.
// R04 - Signature samples before filter/generator/encoder; those add own signals.
// R05 - Test mode chains five state machine registers plus control bits.
// R06 - Scan chain serial output drives one signature input bit.
// R07 - Setting run bit initialises datapath, LFSR, signature, scan mode.
// R08 - After init LFSR and signature advance every byte clock.
// R09 - Sixteen-bit LFSR; test ends when LFSR reaches zero, 65535 patterns.
// R10 - On completion signature freezes and is readable by host.
// R11 - Completion of a run-bit started test raises an interrupt.
// R12 - Interrupt clears only by clearing run bit, not by reading.
// R13 - Clearing run bit before completion aborts the self test.
// R14 - Counter segmentation splits counters into parallel 4-bit segments.
// R15 - Segmentation test needs external clock control; factory use only.
// R16 - Boundary scan shifts in, captures in parallel, shifts out.
// R17 - Boundary chain input test pin 0, output scan-out pin, byte clock.
// R18 - Clocks, resets, processor address/control, test and status pins excluded.
// R19 - Only output latches of processor data bus are in the chain.
// R20 - Chain order: receive symbols, optic off, transmit, MAC, parity, data.
// R21 - While self test runs all three loopbacks are forced active.
// R22 - Frozen signature holds until a new test starts, readable after stop. The code holds it until a new test completes.
//----------------------------------------------------------------------
package pst_pkg;
    localparam int LFSR_W = 16;
    localparam int PATH_W = 10;
    localparam int SEG_W = 4;
    localparam int SCAN_W = 32;
    localparam int BSC_W = 5 + 1 + 5 + 10 + 1 + 1 + 10 + 16;
    localparam logic [LFSR_W-1:0] LFSR_SEED = 16'h0001;
    localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hb400;
    localparam logic [LFSR_W-1:0] SIG_TAPS = 16'h8016;
    localparam logic [LFSR_W-1:0] SIG_SEED = 16'h0000;
    localparam logic [2:0] INIT_CYCLES = 3'h2;

    typedef enum logic [1:0] {
        PST_IDLE,
        PST_INIT,
        PST_RUN,
        PST_DONE
    } pst_state_e;

    typedef struct packed {
        logic [PATH_W-1:0] rx_word;
        logic rf_sig;
        logic dsg_sig;
        logic enc_sig;
    } pst_obs_s;

    typedef struct packed {
        logic force_eb_loop;
        logic force_lm_loop;
        logic force_rem_loop;
        logic test_sel;
        logic scan_mode;
        logic path_init;
    } pst_mux_s;

    typedef struct packed {
        pst_state_e state;
        logic [2:0] init_cnt;
        logic [LFSR_W-1:0] lfsr;
        logic [LFSR_W-1:0] sig;
        logic [LFSR_W-1:0] sig_frozen;
        logic [SCAN_W-1:0] scan;
        logic irq;
        logic run_seen;
        logic [1:0] tin_sync;
        logic [BSC_W-1:0] bsc;
    } pst_state_s;
endpackage

// file: testbench/pst_selftest_props.sv
`timescale 1ns/1ns
`default_nettype none
module pst_selftest_props (
    input wire logic clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic run_selftest_bit, // Run bit
    input wire logic seg_test_mode, // Seg mode
    input wire logic bscan_capture, // Capture
    input wire logic [pst_pkg::BSC_W-1:0] bscan_pins, // Pins
    input wire pst_pkg::pst_mux_s mux_ctl, // Overrides
    input wire logic [pst_pkg::LFSR_W-1:0] signature, // Signature
    input wire logic selftest_irq, // Irq
    input wire logic selftest_busy, // Busy
    input wire logic [pst_pkg::SEG_W-1:0] seg_carry_cut, // Cut mask
    input wire logic scan_out_pin // Scan out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    idle_quiet_a: assert property (!selftest_busy |-> mux_ctl == '0)
        else $error("override while idle");
    force_loops_a: assert property (selftest_busy && !mux_ctl.path_init |-> mux_ctl[5:1] == 5'h1f)
        else $error("loops not forced");
    irq_hold_a: assert property (selftest_irq && run_selftest_bit |=> selftest_irq)
        else $error("irq dropped");
    irq_clear_a: assert property (!run_selftest_bit |=> !selftest_irq)
        else $error("irq not cleared");
    abort_a: assert property (selftest_busy && !run_selftest_bit |=> !selftest_busy && !selftest_irq)
        else $error("abort failed");
    sig_freeze_a: assert property (!$rose(selftest_irq) |-> $stable(signature))
        else $error("signature moved");
    seg_cut_a: assert property (seg_carry_cut == {4{seg_test_mode}})
        else $error("segment cut wrong");
    capture_a: assert property (bscan_capture |=> scan_out_pin == $past(bscan_pins[0]))
        else $error("capture head wrong");
endmodule // pst_selftest_props
bind pst_selftest pst_selftest_props u_props (.clk(clk), .reset_n(reset_n),
    .run_selftest_bit(run_selftest_bit), .seg_test_mode(seg_test_mode),
    .bscan_capture(bscan_capture), .bscan_pins(bscan_pins), .mux_ctl(mux_ctl),
    .signature(signature), .selftest_irq(selftest_irq), .selftest_busy(selftest_busy),
    .seg_carry_cut(seg_carry_cut), .scan_out_pin(scan_out_pin));
`default_nettype wire

// file: testbench/pst_np_model.sv
`timescale 1ns/1ns
`default_nettype none
module pst_np_model (
    input wire logic clk, // Byte clock
    input wire logic [pst_pkg::PATH_W-1:0] test_word, // Injected word
    output pst_pkg::pst_obs_s obs // Returned word and filter signals
);
    // One clock loop delay stands in for the whole receive path
    always_ff @(posedge clk) begin
        obs.rx_word <= test_word;
        obs.rf_sig <= ^test_word[4:0];
        obs.dsg_sig <= ^test_word[9:5];
        obs.enc_sig <= test_word[0];
    end
endmodule // pst_np_model
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk, reset_n, run, seg, bsh, bcap, pin0, irq, busy, so;
    logic [pst_pkg::BSC_W-1:0] pins;
    logic [pst_pkg::PATH_W-1:0] tw;
    logic [15:0] sig, keep;
    logic [3:0] cut;
    pst_pkg::pst_obs_s obs;
    pst_pkg::pst_mux_s mux;
    int err_count, n_checks, cyc;
    pst_selftest DUT (.clk(clk), .reset_n(reset_n), .run_selftest_bit(run), .obs(obs),
        .fsm_scan_load(32'h5a3c_96e1), .seg_test_mode(seg), .bscan_shift(bsh),
        .bscan_capture(bcap), .test_pin0(pin0), .bscan_pins(pins), .test_word(tw),
        .mux_ctl(mux), .signature(sig), .selftest_irq(irq), .selftest_busy(busy),
        .seg_carry_cut(cut), .scan_out_pin(so));
    pst_np_model u_np (.clk(clk), .test_word(tw), .obs(obs));
    // Clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic t_seg();
        @(posedge clk) seg <= 1'b1;
        @(negedge clk) cmp("cut", 16'h000f, 16'(cut));
        @(posedge clk) seg <= 1'b0;
    endtask
    task automatic t_bscan();
        logic [15:0] e;
        @(posedge clk) begin pins <= 49'h1_a5c3_9e17_60f2; bcap <= 1'b1; end
        @(posedge clk) begin bcap <= 1'b0; bsh <= 1'b1; pin0 <= 1'b1; end
        // Data bit 0 leaves first; then two synchroniser zeros, then pin 0
        for (int i = 0; i < pst_pkg::BSC_W + 4; i++) begin
            e = (i < pst_pkg::BSC_W) ? 16'(pins[i]) : 16'(i > pst_pkg::BSC_W + 1);
            @(negedge clk) cmp("scan_out", e, 16'(so));
        end
        @(posedge clk) begin bsh <= 1'b0; pin0 <= 1'b0; end
    endtask
    task automatic t_abort();
        logic [15:0] e;
        e = pst_pkg::LFSR_SEED;
        keep = sig;
        @(posedge clk) run <= 1'b1;
        repeat (10) @(posedge clk);
        // Three init cycles, then six LFSR steps past the seed
        repeat (6) e = (e >> 1) ^ (e[0] ? pst_pkg::LFSR_TAPS : 16'h0000);
        @(negedge clk) cmp("forced", 16'h003e, 16'(mux));
        cmp("test_word", {6'h00, e[9:0]}, 16'(tw));
        @(posedge clk) run <= 1'b0;
        @(posedge clk);
        @(negedge clk) cmp("ab_state", 16'h0000, {14'h0000, busy, irq});
        cmp("ab_sig", keep, sig);
    endtask
    task automatic t_full();
        @(posedge clk) run <= 1'b1;
        cyc = 0;
        while (irq !== 1'b1 && cyc < 70000) begin
            @(negedge clk);
            cyc++;
        end
        cmp("span", 16'h0001, 16'(cyc inside {[65535:65545]}));
        cmp("done", 16'h0000, {busy, 9'h0, mux});
        cmp("sig_set", 16'h0001, 16'(sig != 16'h0000));
        keep = sig;
        repeat (5) @(negedge clk);
        cmp("irq_held", 16'h0001, 16'(irq));
        @(posedge clk) run <= 1'b0;
        @(posedge clk);
        @(negedge clk) cmp("cleared", 16'h0000, 16'(irq));
        cmp("kept_sig", keep, sig);
    endtask
    // Watchdog well past one full run
    initial begin
        #1800000;
        err_count++;
        end_sim();
    end
    initial begin
        {reset_n, run, seg, bsh, bcap, pin0, pins, err_count, n_checks} = '0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk) cmp("reset", 16'h0000, sig);
        t_seg();
        t_bscan();
        t_abort();
        t_full();
        t_abort();
        end_sim();
    end
endmodule // tb
`default_nettype wire
